// *** psc_pkg.sv ***
package psc_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [31:0] PMU_ADDR  = 32'h5000_0010;
  localparam logic [31:0] SYS_ADDR  = 32'h5000_0012;
  localparam logic [31:0] STAT_ADDR = 32'h5000_0014;

  // Writable bits and reset values
  localparam logic [15:0] PMU_MASK = 16'h007F;
  localparam logic [15:0] PMU_RST  = 16'h0006;
  localparam logic [15:0] SYS_MASK = 16'h07FF;
  localparam logic [15:0] SYS_RST  = 16'h0020;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int PMU_MAP      = 6;
  localparam int PMU_DIV_LO   = 4;
  localparam int PMU_RADIO    = 2;
  localparam int PMU_TIM      = 1;
  localparam int PMU_ROW      = 0;
  localparam int SYS_SWRST    = 15;
  localparam int SYS_TODIS    = 10;
  localparam int SYS_DBG_LO   = 7;
  localparam int SYS_NVMRST   = 6;
  localparam int SYS_COPY     = 4;
  localparam int SYS_EMUL     = 2;
  localparam int SYS_REMAP_LO = 0;
  localparam int STAT_DBG     = 0;
  localparam int STAT_BUSY    = 1;
  localparam int STAT_TMO     = 2;
  localparam int STAT_WAIT    = 3;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_PS  = 25000;
  localparam int PSM_TIMEOUT_NS = 2000000;
  localparam int PSM_TIMEOUT_CYC =
    (PSM_TIMEOUT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TMO_W = 24;

  // Mirror size: 32 kB of 32-bit words
  localparam int NVM_WORDS = 8192;
  localparam int NVM_AW    = 13;

  // ****************************************
  // Pins and encodings
  // ****************************************
  localparam int PIN_P1  = 0;
  localparam int PIN_P2  = 1;
  localparam int PIN_P5  = 2;
  localparam int PIN_P10 = 3;
  localparam int NPINS   = 4;

  localparam logic [1:0] DBG_OFF = 2'h0;
  localparam logic [1:0] DBG_P5  = 2'h1;
  localparam logic [1:0] DBG_P1  = 2'h2;
  localparam logic [1:0] DBG_P10 = 2'h3;

  typedef enum logic [1:0] {
    PSC_IDLE = 2'h0,
    PSC_WAIT = 2'h1,
    PSC_COPY = 2'h3,
    PSC_DONE = 2'h2
  } psc_state_t;

endpackage

// *** psc_pin_mux.sv ***
`timescale 1ns/1ps
module psc_pin_mux
(
  input  wire logic       core_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       map_en_i,
  input  wire logic [1:0] dbg_sel_i,
  input  wire logic       reference_on_i,
  input  wire logic       woken_i,
  input  wire logic [3:0] gpio_out_i,
  input  wire logic [3:0] gpio_oe_n_i,
  input  wire logic [3:0] pad_in_i,
  input  wire logic       dbg_dio_out_i,
  input  wire logic       dbg_dio_oe_n_i,
  output logic      [3:0] pad_out_o,
  output logic      [3:0] pad_oe_n_o,
  output logic            dbg_clk_o,
  output logic            dbg_dio_in_o
);

  typedef struct packed {
    logic [3:0] pad_out;
    logic [3:0] pad_oe_n;
    logic       dbg_clk;
    logic       dbg_dio_in;
  } psc_mux_t;

  psc_mux_t r;
  psc_mux_t next_r;

  // Debug data pin index for a selector code
  function automatic logic [1:0] dio_pin(input logic [1:0] sel);
    unique case (sel)
      psc_pkg::DBG_P1:  dio_pin = 2'(psc_pkg::PIN_P1);
      psc_pkg::DBG_P10: dio_pin = 2'(psc_pkg::PIN_P10);
      default:          dio_pin = 2'(psc_pkg::PIN_P5);
    endcase
  endfunction

  // ****************************************
  // Pin ownership
  // ****************************************
  // Priority: diagnostics over debugger over GPIO
  always_comb
  begin
    next_r = r;
    for (int i = 0; i < psc_pkg::NPINS; i++)
    begin
      next_r.pad_out[i]  = gpio_out_i[i];
      next_r.pad_oe_n[i] = gpio_oe_n_i[i];
    end
    next_r.dbg_clk    = 1'b0;
    next_r.dbg_dio_in = 1'b1;
    if (dbg_sel_i != psc_pkg::DBG_OFF)
    begin
      // Clock pin is an input while the debugger owns it
      next_r.pad_oe_n[psc_pkg::PIN_P2] = 1'b1;
      next_r.pad_out[dio_pin(dbg_sel_i)]  = dbg_dio_out_i;
      next_r.pad_oe_n[dio_pin(dbg_sel_i)] = dbg_dio_oe_n_i;
      next_r.dbg_clk    = pad_in_i[psc_pkg::PIN_P2];
      next_r.dbg_dio_in = pad_in_i[dio_pin(dbg_sel_i)];
    end
    if (map_en_i)
    begin
      // P2 direction comes from software, P1 keeps its GPIO or debugger direction; only the level is taken over
      next_r.pad_out[psc_pkg::PIN_P2] = reference_on_i;
      next_r.pad_out[psc_pkg::PIN_P1] = woken_i;
      next_r.pad_oe_n[psc_pkg::PIN_P2] = gpio_oe_n_i[psc_pkg::PIN_P2];
    end
  end

  // State register, all pins released at reset
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      r <= '{pad_out: 4'h0, pad_oe_n: 4'hF, dbg_clk: 1'b0, dbg_dio_in: 1'b1};
    end
    else
    begin
      r <= next_r;
    end
  end

  assign pad_out_o    = r.pad_out;
  assign pad_oe_n_o   = r.pad_oe_n;
  assign dbg_clk_o    = r.dbg_clk;
  assign dbg_dio_in_o = r.dbg_dio_in;

endmodule

// *** psc_regs.sv ***
// Implementation choice: strobed register access.
`timescale 1ns/1ps
module psc_regs
#(
  parameter int TIMEOUT_CYCLES = psc_pkg::PSM_TIMEOUT_CYC,
  parameter int COPY_WORDS     = psc_pkg::NVM_WORDS
)
(
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  // Register bus
  input  wire logic [31:0] reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [15:0] reg_rdata_o,
  // Sequencer and status inputs
  input  wire logic        dbg_attached_i,
  input  wire logic        sys_wake_i,
  input  wire logic        blocks_ready_i,
  // Pin side inputs
  input  wire logic        reference_on_i,
  input  wire logic        woken_i,
  input  wire logic [3:0]  gpio_out_i,
  input  wire logic [3:0]  gpio_oe_n_i,
  input  wire logic [3:0]  pad_in_i,
  input  wire logic        dbg_dio_out_i,
  input  wire logic        dbg_dio_oe_n_i,
  // Mirror source data
  input  wire logic [31:0] nvm_rdata_i,
  // Pad drive and debug pins
  output logic      [3:0]  pad_out_o,
  output logic      [3:0]  pad_oe_n_o,
  output logic             dbg_clk_o,
  output logic             dbg_dio_in_o,
  // Power-domain, reset, bus clock and sequencer controls
  output logic             radio_powerdown_o,
  output logic             timer_powerdown_o,
  output logic             nvm_ctrl_reset_o,
  output logic      [1:0]  boot_remap_o,
  output logic             full_reset_o,
  output logic             wake_reset_o,
  output logic      [1:0]  bus_clk_div_o,
  output logic             psm_done_o,
  // Copy engine toward RAM
  output logic             nvm_rd_o,
  output logic      [12:0] nvm_addr_o,
  output logic             ram_we_o,
  output logic      [12:0] ram_addr_o,
  output logic      [31:0] ram_wdata_o
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [15:0]          pmu;
    logic [15:0]          sys;
    logic [1:0]           remap;
    logic [15:0]          rdata;
    psc_pkg::psc_state_t  state;
    logic [23:0]          tmo_cnt;
    logic                 tmo_hit;
    logic [2:0]           div_cnt;
    logic                 phase;
    logic [12:0]          idx;
    logic [1:0]           clk_div;
    logic                 full_reset;
    logic                 wake_reset;
    logic                 psm_done;
    logic                 nvm_rd;
    logic [12:0]          nvm_addr;
    logic                 ram_we;
    logic [12:0]          ram_addr;
    logic [31:0]          ram_wdata;
  } psc_regs_t;

  psc_regs_t r;
  psc_regs_t next_r;

  // Counter end points; both counters start at zero
  localparam logic [23:0] TMO_LAST  = 24'(TIMEOUT_CYCLES - 1);
  localparam logic [12:0] COPY_LAST = 13'(COPY_WORDS - 1);

  // ****************************************
  // Helpers
  // ****************************************
  // Address decode, shared by read and write paths
  function automatic logic [1:0] reg_sel(input logic [31:0] a);
    if (a == psc_pkg::PMU_ADDR)
      reg_sel = 2'h1;
    else if (a == psc_pkg::SYS_ADDR)
      reg_sel = 2'h2;
    else if (a == psc_pkg::STAT_ADDR)
      reg_sel = 2'h3;
    else
      reg_sel = 2'h0;
  endfunction

  // Mask of divider bits that must be zero for a step
  // Divide by 2^d: a step only when the low d counter bits are zero,
  // which keeps the copy engine in lockstep with the slowed bus clock
  function automatic logic [2:0] div_mask(input logic [1:0] d);
    div_mask = 3'(({1'b0, 3'h0} | (4'h1 << d)) - 4'h1);
  endfunction

  logic [1:0] wr_sel;
  logic [1:0] rd_sel;
  logic       tick;
  logic       sw_rst;
  logic [15:0] status;

  // Bus decode and divider tick
  always_comb
  begin
    wr_sel = reg_wr_i ? reg_sel(reg_addr_i) : 2'h0;
    rd_sel = reg_rd_i ? reg_sel(reg_addr_i) : 2'h0;
    // Copy steps slow down with the divided bus clock
    tick   = (r.div_cnt & div_mask(r.pmu[psc_pkg::PMU_DIV_LO +: 2])) == 3'h0;
    // Only a written one starts the reset
    sw_rst = (wr_sel == 2'h2) && reg_wdata_i[psc_pkg::SYS_SWRST];
  end

  // ****************************************
  // Status word
  // ****************************************
  // Status word, reserved bits read zero
  always_comb
  begin
    status = 16'h0000;
    status[psc_pkg::STAT_DBG]  = dbg_attached_i;
    status[psc_pkg::STAT_BUSY] = (r.state == psc_pkg::PSC_COPY);
    status[psc_pkg::STAT_TMO]  = r.tmo_hit;
    status[psc_pkg::STAT_WAIT] = (r.state == psc_pkg::PSC_WAIT);
  end

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb
  begin
    next_r            = r;
    next_r.full_reset = 1'b0;
    next_r.wake_reset = 1'b0;
    next_r.psm_done   = 1'b0;
    next_r.nvm_rd     = 1'b0;
    next_r.ram_we     = 1'b0;
    next_r.rdata      = 16'h0000;
    next_r.div_cnt    = r.div_cnt + 3'h1;

    // Read data valid only in the cycle after the strobe
    unique case (rd_sel)
      2'h1:    next_r.rdata = r.pmu & psc_pkg::PMU_MASK;
      2'h2:    next_r.rdata = r.sys & psc_pkg::SYS_MASK;
      2'h3:    next_r.rdata = status;
      default: next_r.rdata = 16'h0000;
    endcase

    // Register writes; bit 15 of system control is never stored
    if (wr_sel == 2'h1)
      next_r.pmu = reg_wdata_i & psc_pkg::PMU_MASK;
    if (wr_sel == 2'h2)
      next_r.sys = reg_wdata_i & psc_pkg::SYS_MASK;

    // ****************************************
    // Power sequencer
    // ****************************************
    // Power sequencer after wakeup
    unique case (r.state)
      // Idle until the system domain reports wakeup
      psc_pkg::PSC_IDLE:
      begin
        if (sys_wake_i)
        begin
          next_r.state   = psc_pkg::PSC_WAIT;
          next_r.tmo_cnt = '0;
          next_r.tmo_hit = 1'b0;
        end
      end
      // Wait for start-up, bounded by the timeout unless disabled
      psc_pkg::PSC_WAIT:
      begin
        next_r.tmo_cnt = r.tmo_cnt + 24'h1;
        if (blocks_ready_i || (!r.sys[psc_pkg::SYS_TODIS] && r.tmo_cnt == TMO_LAST))
        begin
          next_r.tmo_hit = !blocks_ready_i;
          if (r.pmu[psc_pkg::PMU_ROW])
          begin
            // Full reboot instead of resuming
            next_r.wake_reset = 1'b1;
            next_r.state      = psc_pkg::PSC_IDLE;
          end
          else if (r.sys[psc_pkg::SYS_COPY])
          begin
            next_r.state = psc_pkg::PSC_COPY;
            next_r.idx   = '0;
            // Divider restarts so emulated and real copies take equal time
            next_r.div_cnt = '0;
            next_r.phase = 1'b0;
          end
          else
          begin
            next_r.state = psc_pkg::PSC_DONE;
          end
        end
      end
      // Two steps per word: fetch, then store one tick later
      psc_pkg::PSC_COPY:
      begin
        if (tick)
        begin
          if (!r.phase)
          begin
            next_r.nvm_rd   = 1'b1;
            next_r.nvm_addr = r.idx;
            next_r.phase    = 1'b1;
          end
          else
          begin
            // Emulation keeps every step, only the write is dropped
            next_r.ram_we    = !r.sys[psc_pkg::SYS_EMUL];
            next_r.ram_addr  = r.idx;
            next_r.ram_wdata = nvm_rdata_i;
            next_r.phase     = 1'b0;
            if (r.idx == COPY_LAST)
              next_r.state = psc_pkg::PSC_DONE;
            else
              next_r.idx = r.idx + 13'h1;
          end
        end
      end
      // One-cycle end pulse, then back to idle
      psc_pkg::PSC_DONE:
      begin
        next_r.psm_done = 1'b1;
        next_r.state    = psc_pkg::PSC_IDLE;
      end
    endcase

    // ****************************************
    // Bus clock division
    // ****************************************
    // Bus clock division applies only while mirroring
    next_r.clk_div = (next_r.state == psc_pkg::PSC_COPY) ?
                     next_r.pmu[psc_pkg::PMU_DIV_LO +: 2] : 2'h0;

    // ****************************************
    // Software reset
    // ****************************************
    // Software reset: power control, sequencer and copy engine restart; system control keeps the written value
    if (sw_rst)
    begin
      next_r.full_reset = 1'b1;
      next_r.pmu        = psc_pkg::PMU_RST;
      next_r.state      = psc_pkg::PSC_IDLE;
      next_r.tmo_cnt    = '0;
      next_r.tmo_hit    = 1'b0;
      next_r.idx        = '0;
      next_r.phase      = 1'b0;
      next_r.clk_div    = 2'h0;
      next_r.nvm_rd     = 1'b0;
      next_r.ram_we     = 1'b0;
      // Remap is sampled only here, so a plain write cannot move code
      next_r.remap = reg_wdata_i[psc_pkg::SYS_REMAP_LO +: 2];
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      // Clear all, then load the non-zero reset levels
      r       <= '0;
      r.pmu   <= psc_pkg::PMU_RST;
      r.sys   <= psc_pkg::SYS_RST;
      r.state <= psc_pkg::PSC_IDLE;
    end
    else
    begin
      r <= next_r;
    end
  end

  // ****************************************
  // Pin multiplexing
  // ****************************************
  psc_pin_mux u_pin_mux
  (
    .core_clk_i     (core_clk_i),
    .rst_n_i        (rst_n_i),
    .map_en_i       (r.pmu[psc_pkg::PMU_MAP]),
    .dbg_sel_i      (r.sys[psc_pkg::SYS_DBG_LO +: 2]),
    .reference_on_i (reference_on_i),
    .woken_i        (woken_i),
    .gpio_out_i     (gpio_out_i),
    .gpio_oe_n_i    (gpio_oe_n_i),
    .pad_in_i       (pad_in_i),
    .dbg_dio_out_i  (dbg_dio_out_i),
    .dbg_dio_oe_n_i (dbg_dio_oe_n_i),
    .pad_out_o      (pad_out_o),
    .pad_oe_n_o     (pad_oe_n_o),
    .dbg_clk_o      (dbg_clk_o),
    .dbg_dio_in_o   (dbg_dio_in_o)
  );

  // ****************************************
  // Outputs, all from flops
  // ****************************************
  assign reg_rdata_o       = r.rdata;
  assign radio_powerdown_o = r.pmu[psc_pkg::PMU_RADIO];
  assign timer_powerdown_o = r.pmu[psc_pkg::PMU_TIM];
  assign nvm_ctrl_reset_o  = r.sys[psc_pkg::SYS_NVMRST];
  assign boot_remap_o      = r.remap;
  // One-cycle pulses, bus clock divider and copy-engine strobes
  assign full_reset_o      = r.full_reset;
  assign wake_reset_o      = r.wake_reset;
  assign bus_clk_div_o     = r.clk_div;
  assign psm_done_o        = r.psm_done;
  assign nvm_rd_o          = r.nvm_rd;
  assign nvm_addr_o        = r.nvm_addr;
  assign ram_we_o          = r.ram_we;
  assign ram_addr_o        = r.ram_addr;
  assign ram_wdata_o       = r.ram_wdata;

endmodule

// *** psc_regs_sva.sv ***
`timescale 1ns/1ps
// ****************************************
// Register bank checker
// ****************************************
module psc_regs_chk
(
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [31:0] reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [15:0] reg_rdata_o,
  input  wire logic        radio_powerdown_o,
  input  wire logic        timer_powerdown_o,
  input  wire logic        nvm_ctrl_reset_o,
  input  wire logic [1:0]  boot_remap_o,
  input  wire logic        full_reset_o,
  input  wire logic        psm_done_o,
  input  wire logic        nvm_rd_o,
  input  wire logic [12:0] nvm_addr_o,
  input  wire logic        ram_we_o,
  input  wire logic [12:0] ram_addr_o
);
  // Decoded writes, kept outside the properties for readability
  wire logic sys_wr = reg_wr_i && (reg_addr_i == psc_pkg::SYS_ADDR);
  wire logic pmu_wr = reg_wr_i && (reg_addr_i == psc_pkg::PMU_ADDR);

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // Bus answers and software reset
  chk_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 16'h0000)
    else $error("read data not zero outside a read");
  chk_swrst_bit: assert property (sys_wr && reg_wdata_i[15] |=> full_reset_o)
    else $error("software reset pulse missing");
  chk_swrst_zero: assert property (reg_wr_i && !(sys_wr && reg_wdata_i[15]) |=> !full_reset_o)
    else $error("reset pulse without a one written");
  chk_swrst_read: assert property (reg_rd_i && reg_addr_i == psc_pkg::SYS_ADDR |=> !reg_rdata_o[15])
    else $error("write-only bit reads back");
  chk_remap_late: assert property ($changed(boot_remap_o) |-> full_reset_o)
    else $error("remap moved without software reset");

  // Power-down and request levels follow the written value
  chk_radio_pd: assert property (pmu_wr |=> radio_powerdown_o == $past(reg_wdata_i[2]))
    else $error("radio power-down level wrong");
  chk_timer_pd: assert property (pmu_wr |=> timer_powerdown_o == $past(reg_wdata_i[1]))
    else $error("timer power-down level wrong");
  chk_nvm_rstreq: assert property (sys_wr |=> nvm_ctrl_reset_o == $past(reg_wdata_i[6]))
    else $error("memory controller reset request wrong");

  // A fetch stays open until its RAM write; the gap grows with the divider
  logic fetch_open;
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      fetch_open <= 1'b0;
    else if (nvm_rd_o)
      fetch_open <= 1'b1;
    else if (ram_we_o)
      fetch_open <= 1'b0;
  end

  // Each RAM write comes from the word fetched just before
  chk_copy_pair: assert property (ram_we_o |-> fetch_open && ram_addr_o == nvm_addr_o)
    else $error("RAM write not paired with a fetch");

  cov_swrst: cover property (full_reset_o);
  cov_copy: cover property (ram_we_o);
  cov_done: cover property (psm_done_o);
endmodule

bind psc_regs psc_regs_chk psc_regs_chk_i (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .radio_powerdown_o(radio_powerdown_o),
  .timer_powerdown_o(timer_powerdown_o), .nvm_ctrl_reset_o(nvm_ctrl_reset_o),
  .boot_remap_o(boot_remap_o), .full_reset_o(full_reset_o), .psm_done_o(psm_done_o),
  .nvm_rd_o(nvm_rd_o), .nvm_addr_o(nvm_addr_o), .ram_we_o(ram_we_o), .ram_addr_o(ram_addr_o));

// *** power_and_system_control_regs_tb_top.sv ***
`timescale 1ns/1ps
// ****************************************
// Register bank testbench
// ****************************************
module power_and_system_control_regs_tb_top;
  logic        core_clk_i = 0, rst_n_i = 0, reg_wr_i = 0, reg_rd_i = 0, sys_wake_i = 0;
  logic        dbg_attached_i = 1, blocks_ready_i = 1, reference_on_i = 0, woken_i = 0;
  logic        dbg_dio_out_i = 0, dbg_dio_oe_n_i = 1;
  logic [31:0] reg_addr_i = 32'h0;
  logic [15:0] reg_wdata_i = 16'h0;
  logic [3:0]  gpio_out_i = 4'h5, gpio_oe_n_i = 4'hA, pad_in_i = 4'h0;
  logic [15:0] reg_rdata_o;
  logic [3:0]  pad_out_o, pad_oe_n_o;
  logic        dbg_clk_o, dbg_dio_in_o, radio_powerdown_o, timer_powerdown_o, nvm_ctrl_reset_o;
  logic        full_reset_o, wake_reset_o, psm_done_o, nvm_rd_o, ram_we_o;
  logic [1:0]  boot_remap_o, bus_clk_div_o;
  logic [12:0] nvm_addr_o, ram_addr_o;
  logic [31:0] ram_wdata_o, got;
  int          n_errors = 0, total_checks = 0, cyc, nwe, cyc0, k;
  int          pidx[4] = '{0, 2, 0, 3};
  // Memory answers with a word derived from its address, held as long as the address
  wire  [31:0] nvm_rdata_i = 32'hA5A5_0000 | {19'h0, nvm_addr_o};

  // 40 MHz clock
  always #12.5 core_clk_i = ~core_clk_i;

  psc_regs #(.TIMEOUT_CYCLES(20), .COPY_WORDS(4)) psc_regs_i (.core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .dbg_attached_i(dbg_attached_i),
    .sys_wake_i(sys_wake_i), .blocks_ready_i(blocks_ready_i), .reference_on_i(reference_on_i),
    .woken_i(woken_i), .gpio_out_i(gpio_out_i), .gpio_oe_n_i(gpio_oe_n_i), .pad_in_i(pad_in_i),
    .dbg_dio_out_i(dbg_dio_out_i), .dbg_dio_oe_n_i(dbg_dio_oe_n_i), .nvm_rdata_i(nvm_rdata_i),
    .pad_out_o(pad_out_o), .pad_oe_n_o(pad_oe_n_o), .dbg_clk_o(dbg_clk_o),
    .dbg_dio_in_o(dbg_dio_in_o), .radio_powerdown_o(radio_powerdown_o),
    .timer_powerdown_o(timer_powerdown_o), .nvm_ctrl_reset_o(nvm_ctrl_reset_o),
    .boot_remap_o(boot_remap_o), .full_reset_o(full_reset_o), .wake_reset_o(wake_reset_o),
    .bus_clk_div_o(bus_clk_div_o), .psm_done_o(psm_done_o), .nvm_rd_o(nvm_rd_o),
    .nvm_addr_o(nvm_addr_o), .ram_we_o(ram_we_o), .ram_addr_o(ram_addr_o),
    .ram_wdata_o(ram_wdata_o));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic end_sim;
    if (n_errors == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Every strobe-driving task starts and ends just after a rising edge; the idle edge avoids re-driving strobes
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask

  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    tick(1);
    reg_wr_i <= 1'b0;
    tick(1);
  endtask

  task automatic rdc(input logic [31:0] a, input logic [15:0] e);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    tick(1);
    reg_rd_i <= 1'b0;
    @(negedge core_clk_i);
    chk({16'h0, reg_rdata_o}, {16'h0, e});
    tick(1);
  endtask

  // One wake-up sequence; checks each mirrored word, counts cycles to the end pulse
  task automatic run_wake(input int rdy_at);
    cyc = 0;
    nwe = 0;
    sys_wake_i <= 1'b1;
    tick(1);
    sys_wake_i <= 1'b0;
    got = 0;
    while (got == 0)
    begin
      @(negedge core_clk_i);
      cyc++;
      if (ram_we_o === 1'b1)
      begin
        chk({19'h0, ram_addr_o}, nwe);
        chk(ram_wdata_o, 32'hA5A5_0000 | nwe);
        nwe++;
      end
      if (nvm_rd_o === 1'b1)
        chk({30'h0, bus_clk_div_o}, 32'h1);
      if (psm_done_o === 1'b1)
        got = 1;
      if (wake_reset_o === 1'b1)
        got = 2;
      @(posedge core_clk_i);
      if (cyc == rdy_at)
        blocks_ready_i <= 1'b1;
      if (cyc > 500)
      begin
        n_errors++;
        $display("mismatch at %0t: sequence never ended", $time);
        end_sim();
      end
    end
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    tick(6);
    rst_n_i <= 1'b1;
    tick(1);
    rdc(psc_pkg::PMU_ADDR, 16'h0006);
    rdc(psc_pkg::SYS_ADDR, 16'h0020);
    rdc(psc_pkg::STAT_ADDR, 16'h0001);
    rdc(32'h5000_0016, 16'h0000);
    wr(psc_pkg::PMU_ADDR, 16'hFFFE);
    rdc(psc_pkg::PMU_ADDR, 16'h007E);
    chk(radio_powerdown_o, 1'b1);
    wr(psc_pkg::PMU_ADDR, 16'h0000);
    chk({radio_powerdown_o, timer_powerdown_o}, 2'h0);
    // Remap is stored but held back until a software reset
    wr(psc_pkg::SYS_ADDR, 16'h07FF);
    rdc(psc_pkg::SYS_ADDR, 16'h07FF);
    chk({nvm_ctrl_reset_o, boot_remap_o}, 3'h4);
    wr(psc_pkg::SYS_ADDR, 16'h8002);
    rdc(psc_pkg::SYS_ADDR, 16'h0002);
    chk({nvm_ctrl_reset_o, boot_remap_o}, 3'h2);
    rdc(psc_pkg::PMU_ADDR, 16'h0006);
    // Each debugger selection routes its data pin and frees P0[2] as input
    for (k = 1; k < 4; k++)
    begin
      wr(psc_pkg::SYS_ADDR, 16'(k << 7));
      pad_in_i <= ~(4'h1 << pidx[k]);
      tick(2);
      @(negedge core_clk_i);
      chk({dbg_clk_o, dbg_dio_in_o, pad_oe_n_o[1]}, 3'h5);
      tick(1);
    end
    wr(psc_pkg::SYS_ADDR, 16'h0000);
    tick(2);
    chk({pad_out_o, pad_oe_n_o}, {gpio_out_i, gpio_oe_n_i});
    // Host detaches before the diagnostics map takes over P0[2]
    dbg_attached_i <= 1'b0;
    wr(psc_pkg::PMU_ADDR, 16'h0040);
    reference_on_i <= 1'b1;
    tick(2);
    chk(pad_out_o[1:0], 2'h2);
    rdc(psc_pkg::STAT_ADDR, 16'h0000);
    // Real mirroring, then its emulation with the same duration
    wr(psc_pkg::PMU_ADDR, 16'h0010);
    wr(psc_pkg::SYS_ADDR, 16'h0010);
    run_wake(1000);
    chk(nwe, 4);
    cyc0 = cyc;
    wr(psc_pkg::SYS_ADDR, 16'h0014);
    run_wake(1000);
    chk(nwe, 0);
    chk(cyc, cyc0);
    chk({30'h0, bus_clk_div_o}, 32'h0);
    // Blocks not ready in time: timeout ends the wait, unless disabled
    blocks_ready_i <= 1'b0;
    wr(psc_pkg::SYS_ADDR, 16'h0000);
    run_wake(1000);
    chk(cyc >= 20 && cyc <= 26, 1'b1);
    rdc(psc_pkg::STAT_ADDR, 16'h0004);
    blocks_ready_i <= 1'b0;
    wr(psc_pkg::SYS_ADDR, 16'h0400);
    run_wake(60);
    chk(cyc > 60, 1'b1);
    wr(psc_pkg::PMU_ADDR, 16'h0001);
    run_wake(1000);
    chk(got, 2);
    // Last remap code only moves with the reset write itself
    wr(psc_pkg::SYS_ADDR, 16'h8003);
    chk(boot_remap_o, 2'h3);
    end_sim();
  end
endmodule
